// [hdl/dms_consts.vh]
// constants for the drive mode select block: offsets, fields, codes
// assumes a 32-bit apb with word-aligned registers
`ifndef DMS_CONSTS_VH
`define DMS_CONSTS_VH

// register byte offsets
`define DMS_OFS_MODE_SEL   8'h00
`define DMS_OFS_CTRL       8'h04
`define DMS_OFS_STATUS     8'h08
`define DMS_OFS_TARGET_VEL 8'h0c
`define DMS_OFS_SPEC_EN    8'h10
`define DMS_OFS_SPEC_CODE  8'h14
`define DMS_OFS_STORE      8'h18
`define DMS_OFS_RESTART    8'h1c
`define DMS_OFS_VEL_SCALE  8'h20
`define DMS_OFS_PROG_RUN   8'h24
`define DMS_OFS_ACTIVE     8'h28

// operating mode codes
`define DMS_MODE_AUTOSETUP 8'hfe
`define DMS_MODE_VELOCITY  8'h02
`define DMS_MODE_PULSE_DIR 8'hff

// control word
`define DMS_CTRL_MS_BIT    4
`define DMS_CTRL_STOP      16'h0006
`define DMS_CTRL_ENABLE    16'h000f

// status word
`define DMS_ST_OP_EN_BIT   2
`define DMS_ST_COORD_BIT   9
`define DMS_ST_TARGET_BIT  10
`define DMS_ST_MS_BIT      12

// special drive modes
`define DMS_SPEC_ON        8'h02
`define DMS_STORE_KEY      32'h65766173
`define DMS_RESTART_KEY    32'h00000001

// speeds in rpm
`define DMS_RPM_TEST       16'd30
`define DMS_RPM_HIGH       16'd1000
`define DMS_RPM_LOW        16'd100

// analog: 12-bit code over 30 V, 20 mV dead zone -> 3 codes
`define DMS_ADC_MID        12'h800
`define DMS_DEAD_CODES     12'h003

`endif

// [hdl/dms_analog_speed.v]
// analog voltage to speed, normal and joystick forms
// assumes adc code is synchronous to clk and already settled
`timescale 1ns/1ps
`include "dms_consts.vh"

module dms_analog_speed #(
  parameter ADC_W = 12
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // controls
  input wire joystick,
  input wire max_low,
  input wire dir_ccw,
  input wire [ADC_W-1:0] adc_code,
  // result
  output reg signed [31:0] speed_q
);

  reg [ADC_W-1:0] mag;
  reg neg;
  reg dead;
  reg [15:0] max_rpm;
  reg [31:0] prod;
  reg signed [31:0] speed_d;

  always @* begin
    max_rpm = max_low ? `DMS_RPM_LOW : `DMS_RPM_HIGH;
    if (joystick) begin
      // midpoint is zero speed; each half spans the full speed range
      neg = (adc_code < `DMS_ADC_MID);
      mag = neg ? (`DMS_ADC_MID - adc_code) : (adc_code - `DMS_ADC_MID);
      dead = (mag <= `DMS_DEAD_CODES);
      prod = {20'h00000, mag} * {16'h0000, max_rpm};
      prod = prod >> (ADC_W - 1);
    end else begin
      // missing direction signal reads low, i.e. clockwise
      neg = dir_ccw;
      mag = adc_code;
      dead = (mag <= `DMS_DEAD_CODES);
      prod = {20'h00000, mag} * {16'h0000, max_rpm};
      prod = prod >> ADC_W;
    end
    if (dead)
      speed_d = 32'sh0;
    else if (neg)
      speed_d = -$signed(prod);
    else
      speed_d = $signed(prod);
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_q <= 32'sh0;
    end else begin
      speed_q <= speed_d;
    end
  end

endmodule // dms_analog_speed

// [hdl/dms_drive_mode_select.v]
// drive mode select: auto setup handshake, velocity test run,
// special drive modes, apb register file
// assumes all inputs synchronous to pclk; measurement engine external
`timescale 1ns/1ps
`include "dms_consts.vh"

module dms_drive_mode_select #(
  parameter ADC_W = 12
) (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // digital and analog inputs
  input wire din3_enable,
  input wire dir_in,
  input wire [ADC_W-1:0] adc_code,
  // measurement engine
  output reg meas_start,
  input wire meas_done,
  input wire meas_ok,
  input wire meas_index_found,
  // storage requests, one-cycle pulses
  output reg store_drive,
  output reg store_tuning,
  output reg store_app,
  // drive outputs
  output reg drive_enable,
  output reg [7:0] op_mode,
  output reg closed_loop,
  output reg pd_select,
  output reg signed [31:0] speed_cmd
);

  // auto setup states
  localparam AS_IDLE = 2'd0;
  localparam AS_RUN = 2'd1;
  localparam AS_SAVE = 2'd2;
  localparam AS_DONE = 2'd3;

  // special mode classes
  localparam SM_PD = 2'd0;
  localparam SM_TEST = 2'd1;
  localparam SM_ANALOG = 2'd2;
  localparam SM_JOY = 2'd3;

  reg [7:0] mode_sel_q;
  reg [15:0] ctrl_q;
  reg signed [31:0] target_vel_q;
  reg [7:0] spec_en_q;
  reg [3:0] spec_code_q;
  reg [7:0] nv_en_q;
  reg [3:0] nv_code_q;
  reg [7:0] act_en_q;
  reg [3:0] act_code_q;
  reg [15:0] vel_scale_q;
  reg prog_run_q;
  reg [1:0] as_state_q;
  reg as_done_q;
  reg index_q;
  reg coord_ok_q;
  reg op_en_q;
  reg ms_prev_q;

  wire acc_phase = psel & penable & pready;
  wire wr = acc_phase & pwrite;
  wire spec_on = (act_en_q == `DMS_SPEC_ON);
  wire signed [31:0] analog_speed;

  // decodes a special mode code into its class
  function [1:0] spec_class;
    input [3:0] code;
    begin
      case (code[2:1])
        2'b00: spec_class = SM_PD;
        2'b01: spec_class = SM_TEST;
        2'b10: spec_class = SM_ANALOG;
        default: spec_class = SM_JOY;
      endcase
    end
  endfunction

  // address decode used by the slave error, which also gates writes; reads decode by case
  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && (a <= `DMS_OFS_ACTIVE);
    end
  endfunction

  wire [1:0] cls = spec_class(act_code_q);

  // status word assembly
  wire [15:0] status_w = {3'b000, as_done_q, 1'b0, index_q, coord_ok_q,
                          6'b000000, op_en_q, 2'b00};

  // apb handshake: one wait-free access, data registered in setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped(paddr);
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `DMS_OFS_MODE_SEL: prdata <= {24'h000000, mode_sel_q};
          `DMS_OFS_CTRL: prdata <= {16'h0000, ctrl_q};
          `DMS_OFS_STATUS: prdata <= {16'h0000, status_w};
          `DMS_OFS_TARGET_VEL: prdata <= target_vel_q;
          `DMS_OFS_SPEC_EN: prdata <= {24'h000000, spec_en_q};
          `DMS_OFS_SPEC_CODE: prdata <= {28'h0000000, spec_code_q};
          `DMS_OFS_VEL_SCALE: prdata <= {16'h0000, vel_scale_q};
          `DMS_OFS_PROG_RUN: prdata <= {31'h00000000, prog_run_q};
          `DMS_OFS_ACTIVE: prdata <= {20'h00000, act_code_q, act_en_q};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // software-written registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_sel_q <= 8'h00;
      ctrl_q <= 16'h0000;
      spec_en_q <= 8'h00;
      spec_code_q <= 4'h0;
      prog_run_q <= 1'b0;
    end else if (wr && !pslverr) begin
      case (paddr)
        `DMS_OFS_MODE_SEL: mode_sel_q <= pwdata[7:0];
        `DMS_OFS_CTRL: ctrl_q <= pwdata[15:0];
        `DMS_OFS_SPEC_EN: spec_en_q <= pwdata[7:0];
        `DMS_OFS_SPEC_CODE: spec_code_q <= pwdata[3:0];
        `DMS_OFS_PROG_RUN: prog_run_q <= pwdata[0];
        default: ;
      endcase
    end
  end

  // nonvolatile image and active copy of the special mode objects
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_en_q <= 8'h00;
      nv_code_q <= 4'h0;
      act_en_q <= 8'h00;
      act_code_q <= 4'h0;
      store_app <= 1'b0;
    end else begin
      store_app <= 1'b0;
      // store then restart before taking effect
      if (wr && paddr == `DMS_OFS_STORE && pwdata == `DMS_STORE_KEY) begin
        nv_en_q <= spec_en_q;
        nv_code_q <= spec_code_q;
        store_app <= 1'b1;
      end
      if (wr && paddr == `DMS_OFS_RESTART && pwdata == `DMS_RESTART_KEY) begin
        act_en_q <= nv_en_q;
        act_code_q <= nv_code_q;
      end
    end
  end

  // auto setup sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      as_state_q <= AS_IDLE;
      as_done_q <= 1'b0;
      index_q <= 1'b0;
      coord_ok_q <= 1'b1;
      meas_start <= 1'b0;
      store_drive <= 1'b0;
      store_tuning <= 1'b0;
      ms_prev_q <= 1'b0;
    end else begin
      meas_start <= 1'b0;
      store_drive <= 1'b0;
      store_tuning <= 1'b0;
      ms_prev_q <= ctrl_q[`DMS_CTRL_MS_BIT];
      // only a restart makes coordinates valid again
      if (wr && paddr == `DMS_OFS_RESTART && pwdata == `DMS_RESTART_KEY)
        coord_ok_q <= 1'b1;
      case (as_state_q)
        AS_IDLE: begin
          // rising mode bit starts the run
          // refused while a user program runs
          if (mode_sel_q == `DMS_MODE_AUTOSETUP && op_en_q && !spec_on &&
              !prog_run_q && ctrl_q[`DMS_CTRL_MS_BIT] && !ms_prev_q) begin
            as_state_q <= AS_RUN;
            as_done_q <= 1'b0;
            meas_start <= 1'b1;
          end
        end
        AS_RUN: begin
          if (meas_done) begin
            index_q <= meas_index_found;
            coord_ok_q <= 1'b0;
            as_state_q <= meas_ok ? AS_SAVE : AS_DONE;
          end
        end
        AS_SAVE: begin
          store_drive <= 1'b1;
          store_tuning <= 1'b1;
          as_state_q <= AS_DONE;
        end
        AS_DONE: begin
          // completion flag held until a new start
          as_done_q <= 1'b1;
          if (!ctrl_q[`DMS_CTRL_MS_BIT])
            as_state_q <= AS_IDLE;
        end
        default: as_state_q <= AS_IDLE;
      endcase
    end
  end

  // power state: control word normally, enable input in special modes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_en_q <= 1'b0;
    end else if (spec_on) begin
      op_en_q <= din3_enable;
    end else if (ctrl_q == `DMS_CTRL_STOP) begin
      op_en_q <= 1'b0;
    end else if ((ctrl_q & `DMS_CTRL_ENABLE) == `DMS_CTRL_ENABLE) begin
      op_en_q <= 1'b1;
    end
  end

  dms_analog_speed #(
    .ADC_W(ADC_W)
  ) u_analog (
    .clk(pclk),
    .rst_n(presetn),
    .joystick(cls == SM_JOY),
    .max_low(act_code_q[0]),
    .dir_ccw(dir_in),
    .adc_code(adc_code),
    .speed_q(analog_speed)
  );

  // target velocity: software-written unless analog mode owns it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_vel_q <= 32'sh0;
    end else if (spec_on && (cls == SM_ANALOG || cls == SM_JOY)) begin
      target_vel_q <= analog_speed;
    end else if (wr && paddr == `DMS_OFS_TARGET_VEL) begin
      target_vel_q <= pwdata;
    end
  end

  // drive outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_enable <= 1'b0;
      op_mode <= 8'h00;
      closed_loop <= 1'b0;
      pd_select <= 1'b0;
      speed_cmd <= 32'sh0;
      vel_scale_q <= `DMS_RPM_HIGH;
    end else begin
      drive_enable <= op_en_q;
      if (spec_on) begin
        // upper half of codes is closed-loop
        closed_loop <= act_code_q[3];
        case (cls)
          SM_PD: begin
            op_mode <= `DMS_MODE_PULSE_DIR;
            pd_select <= 1'b1;
            speed_cmd <= 32'sh0;
          end
          SM_TEST: begin
            op_mode <= `DMS_MODE_VELOCITY;
            pd_select <= 1'b0;
            if (!din3_enable)
              speed_cmd <= 32'sh0;
            else if (act_code_q[0])
              speed_cmd <= -$signed({16'h0000, `DMS_RPM_TEST});
            else
              speed_cmd <= $signed({16'h0000, `DMS_RPM_TEST});
          end
          default: begin
            op_mode <= `DMS_MODE_VELOCITY;
            pd_select <= 1'b0;
            speed_cmd <= op_en_q ? target_vel_q : 32'sh0;
            vel_scale_q <= act_code_q[0] ? `DMS_RPM_LOW : `DMS_RPM_HIGH;
          end
        endcase
      end else begin
        op_mode <= mode_sel_q;
        closed_loop <= 1'b0;
        pd_select <= 1'b0;
        // velocity mode runs the target speed
        if (mode_sel_q == `DMS_MODE_VELOCITY && op_en_q)
          speed_cmd <= target_vel_q;
        else
          speed_cmd <= 32'sh0;
      end
    end
  end

endmodule // dms_drive_mode_select

// [verif/dms_meas_model.sv]
// model of the measurement engine beside the drive mode select block
// assumes one start pulse per run; outcome and run length set by the bench
`timescale 1ns/1ps

module dms_meas_model (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // handshake with the block
  input wire meas_start,
  output reg meas_done,
  output reg meas_ok,
  output reg meas_index_found,
  // outcome chosen by the bench
  input wire [7:0] cfg_wait,
  input wire cfg_ok,
  input wire cfg_index
);
  reg [7:0] cnt_q;
  reg busy_q;
  // runs in turn, index with done
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      busy_q <= 1'b0;
      meas_done <= 1'b0;
      meas_ok <= 1'b0;
      meas_index_found <= 1'b0;
    end else begin
      meas_done <= 1'b0;
      // results mean nothing outside done, so keep them moving
      meas_ok <= ~meas_ok;
      meas_index_found <= ~meas_index_found;
      if (meas_start && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q <= cfg_wait;
      end else if (busy_q && cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        meas_done <= 1'b1;
        meas_ok <= cfg_ok;
        meas_index_found <= cfg_index;
      end
    end
  end
endmodule // dms_meas_model

// [verif/dms_drive_mode_select_chk.sv]
// assertions on the ports of the drive mode select block
// assumes the offsets and keys of dms_consts.vh
`timescale 1ns/1ps
`include "dms_consts.vh"

module dms_drive_mode_select_chk (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  // measurement and storage
  input wire meas_start,
  input wire meas_done,
  input wire meas_ok,
  input wire store_drive,
  input wire store_tuning,
  input wire store_app,
  // drive
  input wire drive_enable,
  input wire [7:0] op_mode,
  input wire closed_loop,
  input wire pd_select
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pready && pwrite;
  wire start_wr = wr && paddr == `DMS_OFS_CTRL && pwdata[`DMS_CTRL_MS_BIT];
  wire app_wr = wr && paddr == `DMS_OFS_STORE && pwdata == `DMS_STORE_KEY;
  wire rst_wr = wr && paddr == `DMS_OFS_RESTART && pwdata == `DMS_RESTART_KEY;
  wire done_ok = meas_done && meas_ok;

  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_start_pulse; meas_start |=> !meas_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_start_cause;
    meas_start |-> $past(start_wr) || $past(start_wr, 2) || $past(start_wr, 3);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without bit 4");
  property p_start_cond; meas_start |-> drive_enable && op_mode == `DMS_MODE_AUTOSETUP; endproperty
  a_start_cond: assert property (p_start_cond) else $error("start not enabled");
  property p_store_pair; store_drive == store_tuning; endproperty
  a_store_pair: assert property (p_store_pair) else $error("store pair split");
  property p_store_cause; store_drive |-> $past(done_ok) || $past(done_ok, 2); endproperty
  a_store_cause: assert property (p_store_cause) else $error("store without success");
  property p_app; store_app |-> $past(app_wr) || $past(app_wr, 2); endproperty
  a_app: assert property (p_app) else $error("app store without key");
  property p_mode_hold;
    $changed(pd_select) || $changed(closed_loop) |->
      $past(rst_wr) || $past(rst_wr, 2) || $past(rst_wr, 3);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved without restart");

  c_start: cover property (meas_start);
  c_store: cover property (store_drive);
  c_pd: cover property ($rose(pd_select));
endmodule // dms_drive_mode_select_chk

bind dms_drive_mode_select dms_drive_mode_select_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .meas_start(meas_start), .meas_done(meas_done), .meas_ok(meas_ok),
  .store_drive(store_drive), .store_tuning(store_tuning), .store_app(store_app),
  .drive_enable(drive_enable), .op_mode(op_mode), .closed_loop(closed_loop),
  .pd_select(pd_select));

// [verif/tb_drive_mode_select_logic.sv]
// self-checking bench for the drive mode select block
// assumes an apb slave that answers in its own time; inputs change at rising edges
`timescale 1ns/1ps
`include "dms_consts.vh"

module tb_drive_mode_select_logic;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg din3_enable = 1'b0;
  reg dir_in = 1'b0;
  reg [11:0] adc_code = 12'h000;
  reg cfg_ok = 1'b1;
  reg cfg_index = 1'b1;
  wire [31:0] prdata;
  wire pready, pslverr, meas_start, meas_done, meas_ok, meas_index_found;
  wire store_drive, store_tuning, store_app, drive_enable, closed_loop, pd_select;
  wire [7:0] op_mode;
  wire signed [31:0] speed_cmd;
  integer fails = 0, checked = 0, cycles = 0, starts = 0, stores = 0, i, n, m;
  integer tunes = 0, apps = 0;
  reg [31:0] rd, e;
  reg err;

  dms_drive_mode_select uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .din3_enable(din3_enable), .dir_in(dir_in), .adc_code(adc_code),
    .meas_start(meas_start), .meas_done(meas_done), .meas_ok(meas_ok),
    .meas_index_found(meas_index_found), .store_drive(store_drive),
    .store_tuning(store_tuning), .store_app(store_app), .drive_enable(drive_enable),
    .op_mode(op_mode), .closed_loop(closed_loop), .pd_select(pd_select),
    .speed_cmd(speed_cmd));
  dms_meas_model u_meas (.pclk(pclk), .presetn(presetn), .meas_start(meas_start),
    .meas_done(meas_done), .meas_ok(meas_ok), .meas_index_found(meas_index_found),
    .cfg_wait(8'd40), .cfg_ok(cfg_ok), .cfg_index(cfg_index));

  initial begin
    forever #50 pclk = ~pclk;
  end

  task summarize;
    begin
      if (fails == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (meas_start === 1'b1) starts <= starts + 1;
    if (store_drive === 1'b1) stores <= stores + 1;
    if (store_tuning === 1'b1) tunes <= tunes + 1;
    if (store_app === 1'b1) apps <= apps + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      summarize;
    end
  end

  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        $display("BAD %0s exp %h got %h", nm, exp, got);
        fails = fails + 1;
      end
    end
  endtask

  task apb(input [7:0] a, input w, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task rdc(input [7:0] a, input [31:0] mask, input [31:0] exp, input string nm);
    begin
      apb(a, 1'b0, 32'h0);
      chk(nm, exp, rd & mask);
    end
  endtask

  task tick(input integer k);
    repeat (k) @(posedge pclk);
  endtask

  // start one auto setup run and check what it reports
  task setup_run(input ok, input idx, input [31:0] st, input integer nst);
    begin
      cfg_ok <= ok;
      cfg_index <= idx;
      wr(`DMS_OFS_CTRL, 32'h0f);
      wr(`DMS_OFS_CTRL, 32'h1f);
      tick(2);
      rdc(`DMS_OFS_STATUS, 32'h1000, 32'h0, "busy");
      n = 0;
      while (meas_done !== 1'b1 && n < 200) begin
        @(posedge pclk);
        n = n + 1;
      end
      tick(3);
      rdc(`DMS_OFS_STATUS, 32'h1604, st, "status");
      chk("stores", nst, stores);
      chk("tunes", nst, tunes);
    end
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`DMS_OFS_VEL_SCALE, 32'hffffffff, 32'd1000, "scale0");
    apb(8'h30, 1'b0, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    wr(`DMS_OFS_MODE_SEL, 32'h2);
    wr(`DMS_OFS_TARGET_VEL, 32'd200);
    wr(`DMS_OFS_CTRL, 32'h0f);
    tick(4);
    chk("vel", 32'h202, {22'h0, drive_enable, 1'b0, op_mode});
    chk("vel_speed", 32'd200, speed_cmd);
    wr(`DMS_OFS_CTRL, {16'h0, `DMS_CTRL_STOP});
    tick(3);
    chk("stop", 32'h0, {31'h0, drive_enable});
    wr(`DMS_OFS_MODE_SEL, 32'hfe);
    wr(`DMS_OFS_PROG_RUN, 32'h1);
    wr(`DMS_OFS_CTRL, 32'h0f);
    wr(`DMS_OFS_CTRL, 32'h1f);
    tick(6);
    chk("blocked", 32'h0, starts);
    wr(`DMS_OFS_PROG_RUN, 32'h0);
    setup_run(1'b1, 1'b1, 32'h1404, 1);
    setup_run(1'b0, 1'b0, 32'h1004, 1);
    chk("starts", 32'd2, starts);
    wr(`DMS_OFS_RESTART, `DMS_RESTART_KEY);
    rdc(`DMS_OFS_STATUS, 32'h0200, 32'h0200, "coords");
    din3_enable <= 1'b1;
    wr(`DMS_OFS_SPEC_EN, 32'h2);
    e = 32'h0;
    for (i = 0; i < 16; i = i + 1) begin
      wr(`DMS_OFS_SPEC_CODE, i);
      rdc(`DMS_OFS_ACTIVE, 32'hfff, e, "held");
      wr(`DMS_OFS_STORE, `DMS_STORE_KEY);
      wr(`DMS_OFS_RESTART, `DMS_RESTART_KEY);
      e = {20'h0, i[3:0], 8'h02};
      adc_code <= 12'h400;
      tick(6);
      rdc(`DMS_OFS_ACTIVE, 32'hfff, e, "active");
      chk("loop", {31'h0, i[3]}, {31'h0, closed_loop});
      m = i[0] ? 100 : 1000;
      case (i[2:0])
        0, 1: chk("pd", 32'h1ff, {23'h0, pd_select, op_mode});
        2, 3: chk("test", i[0] ? -30 : 30, speed_cmd);
        default: begin
          chk("velmode", 32'h2, {24'h0, op_mode});
          chk("ana", i[1] ? -(m / 2) : m / 4, speed_cmd);
          rdc(`DMS_OFS_VEL_SCALE, 32'hffffffff, m, "scale");
          adc_code <= i[1] ? 12'hc00 : 12'h400;
          dir_in <= !i[1];
          tick(6);
          chk("side", i[1] ? m / 2 : -(m / 4), speed_cmd);
          dir_in <= 1'b0;
          adc_code <= i[1] ? 12'h802 : 12'h002;
          tick(6);
          chk("dead", 32'h0, speed_cmd);
        end
      endcase
    end
    chk("apps", 32'd16, apps);
    din3_enable <= 1'b0;
    tick(4);
    chk("en_off", 32'h0, {31'h0, drive_enable});
    wr(`DMS_OFS_CTRL, 32'h0f);
    tick(3);
    chk("ctrl_ign", 32'h0, {31'h0, drive_enable});
    din3_enable <= 1'b1;
    tick(4);
    chk("en_on", 32'h1, {31'h0, drive_enable});
    summarize;
  end
endmodule // tb_drive_mode_select_logic
